// ### src/tbd_pkg.sv
package tbd_pkg;
  // register byte addresses
  localparam logic [11:0] TBD_BDT_ADDR  = 12'h044;
  localparam logic [11:0] TBD_CHAN_ADDR = 12'h050;
  localparam logic [11:0] TBD_CMP_ADDR  = 12'h054;
  localparam logic [11:0] TBD_STAT_ADDR = 12'h058;
  localparam logic [11:0] TBD_MASK_ADDR = 12'h05C;
  // brake_deadtime_ctrl fields
  localparam int unsigned TBD_DTC_LSB   = 0;
  localparam int unsigned TBD_LOCK_LSB  = 8;
  localparam int unsigned TBD_IDLE_OFF  = 10;
  localparam int unsigned TBD_RUN_OFF   = 11;
  localparam int unsigned TBD_BRK_EN    = 12;
  localparam int unsigned TBD_BRK_POL   = 13;
  localparam int unsigned TBD_AUTO_OE   = 14;
  localparam int unsigned TBD_MOE       = 15;
  localparam logic [15:0] TBD_BDT_RST   = 16'h0000;
  localparam logic [15:0] TBD_LOCK_FLD  = 16'h0300;
  localparam logic [15:0] TBD_L1_MASK   = 16'h70FF;
  localparam logic [15:0] TBD_L2_MASK   = 16'h0C00;
  localparam logic [1:0]  TBD_LOCK_NONE = 2'h0;
  localparam logic [1:0]  TBD_LOCK_L3   = 2'h3;
  // per-channel config: en, pol, comp en, comp pol, idle, comp idle
  localparam int unsigned TBD_CH_W      = 6;
  localparam int unsigned TBD_CMP_W     = 4;
  localparam logic [5:0]  TBD_CH_IDLE_M = 6'h30;
  localparam logic [5:0]  TBD_CH_POL_M  = 6'h0A;
  // status bits
  localparam int unsigned TBD_ST_BRK    = 0;
  localparam int unsigned TBD_ST_AUTO   = 1;
  localparam int unsigned TBD_ST_W      = 2;
  localparam int unsigned TBD_TICK_DIV  = 1;

  typedef struct packed {
    logic comp_idle_state;
    logic output_idle_state;
    logic complementary_polarity;
    logic complementary_enable;
    logic channel_polarity;
    logic channel_enable;
  } tbd_chan_cfg_t;
endpackage : tbd_pkg

// ### src/tbd_brake_deadtime.sv
`timescale 1ns/1ps
`default_nettype none
module tbd_brake_deadtime
  import tbd_pkg::*;
#(
  parameter int unsigned NCH      = 4,
  parameter int unsigned TICK_DIV = TBD_TICK_DIV
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  input  wire logic             break_input,
  input  wire logic             update_evt,
  input  wire logic [NCH-1:0]   ref_wave,
  output logic [NCH-1:0]        channel_output,
  output logic [NCH-1:0]        channel_oe,
  output logic [NCH-1:0]        complementary_output,
  output logic [NCH-1:0]        complementary_oe,
  output logic [3*NCH-1:0]      compare_mode,
  output logic [NCH-1:0]        compare_preload_enable,
  output logic                  irq
);

  if (NCH < 1 || NCH > 4) begin : g_chk_nch
    $error("NCH must be 1 to 4");
  end
  if (TICK_DIV < 1 || TICK_DIV > 255) begin : g_chk_div
    $error("TICK_DIV must be 1 to 255");
  end

  if (TBD_CH_W * NCH > 32 || TBD_CMP_W * NCH > 32) begin : g_chk_map
    $error("channel fields must fit one bus word");
  end

  function automatic logic [9:0] tbd_dead_ticks(input logic [7:0] c);
    logic [9:0] b5;
    logic [9:0] b6;
    b5 = {5'h00, c[4:0]} + 10'h020;
    b6 = {4'h0, c[5:0]} + 10'h040;
    if (!c[7]) return {3'h0, c[6:0]};
    else if (!c[6]) return {b6[8:0], 1'b0};
    else if (!c[5]) return {b5[6:0], 3'h0};
    else return {b5[5:0], 4'h0};
  endfunction : tbd_dead_ticks

  // control register bits that a write may change at each lock level
  function automatic logic [15:0] tbd_bdt_wmask(input logic [1:0] lvl,
                                                input logic       done);
    logic [15:0] m;
    m = 16'h0000;
    if (lvl != TBD_LOCK_NONE) m = m | TBD_L1_MASK;
    if (lvl[1]) m = m | TBD_L2_MASK;
    if (done) m = m | TBD_LOCK_FLD;
    m = m | (16'h0001 << TBD_MOE);
    return ~m;
  endfunction : tbd_bdt_wmask

  // channel config bits that a write may change at each lock level
  function automatic logic [5:0] tbd_ch_wmask(input logic [1:0] lvl);
    logic [5:0] m;
    m = 6'h00;
    if (lvl != TBD_LOCK_NONE) m = m | TBD_CH_IDLE_M;
    if (lvl[1]) m = m | TBD_CH_POL_M;
    return ~m;
  endfunction : tbd_ch_wmask

  // ==========================================================
  // registers and bus decode
  logic [15:0]               bdt_ff;
  logic                      lock_done_ff;
  tbd_chan_cfg_t [NCH-1:0]   chan_ff;
  logic [TBD_CMP_W*NCH-1:0]  cmp_ff;
  logic [TBD_ST_W-1:0]       stat_ff;
  logic [TBD_ST_W-1:0]       mask_ff;
  logic [31:0]               prdata_ff;
  logic                      pol_eff_ff;
  logic                      brk_s1_ff;
  logic                      brk_s2_ff;
  logic                      brk_q_ff;
  logic                      moe_ff;
  logic                      moe_q_ff;
  logic [7:0]                div_ff;
  logic [9:0]                idle_cnt_ff;
  logic [NCH-1:0]            ref_q_ff;
  logic [9:0]                dt_cnt_ff [NCH];
  logic [NCH-1:0]            ch_out_ff;
  logic [NCH-1:0]            ch_oe_ff;
  logic [NCH-1:0]            cp_out_ff;
  logic [NCH-1:0]            cp_oe_ff;

  wire        setup     = psel & ~penable;
  wire        access    = psel & penable;
  wire        hit_bdt   = paddr == TBD_BDT_ADDR;
  wire        hit_chan  = paddr == TBD_CHAN_ADDR;
  wire        hit_cmp   = paddr == TBD_CMP_ADDR;
  wire        hit_stat  = paddr == TBD_STAT_ADDR;
  wire        hit_mask  = paddr == TBD_MASK_ADDR;
  wire        hit_any   = hit_bdt | hit_chan | hit_cmp | hit_stat | hit_mask;
  wire        wr        = access & pwrite;
  wire        wr_bdt    = wr & hit_bdt;
  wire        rd_stat   = access & ~pwrite & hit_stat;
  // lock level as stored; the write that sets it still obeys the old level
  wire [1:0]  lock_lvl  = bdt_ff[TBD_LOCK_LSB +: 2];
  wire        lock_l1   = lock_lvl != TBD_LOCK_NONE;
  wire        lock_l2   = lock_lvl[1];
  wire        lock_l3   = lock_lvl == TBD_LOCK_L3;

  // writable bit masks per lock level
  wire [15:0] bdt_wmask = tbd_bdt_wmask(lock_lvl, lock_done_ff);
  wire [5:0]  ch_wmask  = tbd_ch_wmask(lock_lvl);
  logic [TBD_CH_W*NCH-1:0] chan_wmask;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      chan_wmask[i*TBD_CH_W +: TBD_CH_W] = ch_wmask;
    end
  end
  wire [TBD_CH_W*NCH-1:0] chan_flat = chan_ff;
  wire [TBD_CH_W*NCH-1:0] nxt_chan  = (chan_flat & ~chan_wmask)
                                    | (pwdata[TBD_CH_W*NCH-1:0] & chan_wmask);
  wire [15:0] nxt_bdt_w = (bdt_ff & ~bdt_wmask) | (pwdata[15:0] & bdt_wmask);

  // read words; main enable reads the stored flop, not the forced value
  wire [31:0] rd_bdt_word  = {16'h0000, moe_ff, bdt_ff[14:0]};
  wire [31:0] rd_chan_word = 32'(chan_flat);
  wire [31:0] rd_cmp_word  = 32'(cmp_ff);
  wire [31:0] rd_stat_word = 32'(stat_ff);
  wire [31:0] rd_mask_word = 32'(mask_ff);
  wire [31:0] rd_mux       = ({32{hit_bdt}} & rd_bdt_word)
                           | ({32{hit_chan}} & rd_chan_word)
                           | ({32{hit_cmp}} & rd_cmp_word)
                           | ({32{hit_stat}} & rd_stat_word)
                           | ({32{hit_mask}} & rd_mask_word);

  // ==========================================================
  // bus handshake
  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;
  assign prdata  = prdata_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bdt_ff       <= TBD_BDT_RST;
      lock_done_ff <= 1'b0;
    end else if (wr_bdt) begin
      bdt_ff       <= nxt_bdt_w;
      lock_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_ff <= '0;
      cmp_ff  <= '0;
      mask_ff <= '0;
    end else if (wr) begin
      if (hit_chan) chan_ff <= nxt_chan;
      if (hit_cmp && !lock_l3) cmp_ff <= pwdata[TBD_CMP_W*NCH-1:0];
      if (hit_mask) mask_ff <= pwdata[TBD_ST_W-1:0];
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      compare_mode[3*i +: 3]    = cmp_ff[TBD_CMP_W*i +: 3];
      compare_preload_enable[i] = cmp_ff[TBD_CMP_W*i + 3];
    end
  end

  // ==========================================================
  // break and main output enable
  // brk_s1_ff feeds brk_s2_ff only, so no logic sees a metastable value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_s1_ff  <= 1'b0;
      brk_s2_ff  <= 1'b0;
    end else begin
      brk_s1_ff  <= break_input;
      brk_s2_ff  <= brk_s1_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_eff_ff <= 1'b0;
    end else begin
      pol_eff_ff <= bdt_ff[TBD_BRK_POL];
    end
  end

  // raw pin path gives the clockless clear; the synced path updates state
  wire brk_now  = bdt_ff[TBD_BRK_EN] & ~(break_input ^ pol_eff_ff);
  wire brk_sync = bdt_ff[TBD_BRK_EN] & ~(brk_s2_ff ^ pol_eff_ff);
  wire auto_set = bdt_ff[TBD_AUTO_OE] & update_evt & ~brk_sync;
  wire moe_eff  = moe_ff & ~brk_now;
  wire moe_fall = moe_q_ff & ~moe_eff;

  // a synced break wins over the auto set, which wins over software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      moe_ff   <= 1'b0;
      moe_q_ff <= 1'b0;
      brk_q_ff <= 1'b0;
    end else begin
      moe_q_ff <= moe_eff;
      brk_q_ff <= brk_sync;
      if (brk_sync) moe_ff <= 1'b0;
      else if (auto_set) moe_ff <= 1'b1;
      else if (wr_bdt) moe_ff <= pwdata[TBD_MOE];
    end
  end

  // ==========================================================
  // interrupt status, cleared by reading it, set wins
  wire [TBD_ST_W-1:0] st_set  = {auto_set & ~moe_ff, brk_sync & ~brk_q_ff};
  wire [TBD_ST_W-1:0] st_keep = rd_stat ? '0 : stat_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= st_keep | st_set;
    end
  end
  assign irq = |(stat_ff & mask_ff);

  // ==========================================================
  // dead-time tick and counters
  wire [9:0] dead_ticks = tbd_dead_ticks(bdt_ff[TBD_DTC_LSB +: 8]);
  // tick pulses once per TICK_DIV clocks; all dead-time counts use it
  wire       tick       = div_ff == 8'(TICK_DIV - 1);
  // the first idle cycle after the fall must already be inactive
  wire       idle_done  = idle_cnt_ff == 10'h000 && !moe_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= tick ? 8'h00 : div_ff + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_ff <= 10'h000;
    end else if (moe_fall) begin
      idle_cnt_ff <= dead_ticks;
    end else if (tick && idle_cnt_ff != 10'h000) begin
      idle_cnt_ff <= idle_cnt_ff - 10'h001;
    end
  end

  // ==========================================================
  // per-channel dead time and output drive
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    tbd_chan_cfg_t c;
    logic          ref_on;
    logic          main_act;
    logic          comp_act;
    logic          nxt_co;
    logic          nxt_coe;
    logic          nxt_po;
    logic          nxt_poe;
    logic          brk_co_oe;
    logic          brk_cp_oe;
    assign c        = chan_ff[g];
    assign ref_on   = dt_cnt_ff[g] == 10'h000;
    assign main_act = ref_q_ff[g] & ref_on;
    assign comp_act = ~ref_q_ff[g] & ref_on;

    // every change of the reference restarts the dead time for that leg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ref_q_ff[g]  <= 1'b0;
        dt_cnt_ff[g] <= 10'h000;
      end else if (ref_wave[g] != ref_q_ff[g]) begin
        ref_q_ff[g]  <= ref_wave[g];
        dt_cnt_ff[g] <= dead_ticks;
      end else if (tick && !ref_on) begin
        dt_cnt_ff[g] <= dt_cnt_ff[g] - 10'h001;
      end
    end

    // run mode drives enabled legs from the reference, idle mode parks them
    always_comb begin
      nxt_co  = c.channel_polarity;
      nxt_po  = c.complementary_polarity;
      nxt_coe = 1'b0;
      nxt_poe = 1'b0;
      if (moe_eff) begin
        if (c.channel_enable) begin
          nxt_coe = 1'b1;
          nxt_co  = main_act ^ c.channel_polarity;
        end else if (bdt_ff[TBD_RUN_OFF]) begin
          nxt_coe = 1'b1;
        end
        if (c.complementary_enable) begin
          nxt_poe = 1'b1;
          nxt_po  = comp_act ^ c.complementary_polarity;
        end else if (bdt_ff[TBD_RUN_OFF]) begin
          nxt_poe = 1'b1;
        end
      end else if (bdt_ff[TBD_IDLE_OFF]) begin
        nxt_coe = c.channel_enable;
        nxt_poe = c.complementary_enable;
        if (idle_done) begin
          nxt_co = c.output_idle_state;
          nxt_po = c.comp_idle_state;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ch_out_ff[g] <= 1'b0;
        ch_oe_ff[g]  <= 1'b0;
        cp_out_ff[g] <= 1'b0;
        cp_oe_ff[g]  <= 1'b0;
      end else begin
        ch_out_ff[g] <= nxt_co;
        ch_oe_ff[g]  <= nxt_coe;
        cp_out_ff[g] <= nxt_po;
        cp_oe_ff[g]  <= nxt_poe;
      end
    end

    // ==========================================================
    // an active break forces the pins at once, before the next edge
    assign brk_co_oe = bdt_ff[TBD_IDLE_OFF] & c.channel_enable;
    assign brk_cp_oe = bdt_ff[TBD_IDLE_OFF] & c.complementary_enable;
    assign channel_output[g]       = brk_now ? c.channel_polarity : ch_out_ff[g];
    assign complementary_output[g] = brk_now ? c.complementary_polarity : cp_out_ff[g];
    assign channel_oe[g]           = brk_now ? brk_co_oe : ch_oe_ff[g];
    assign complementary_oe[g]     = brk_now ? brk_cp_oe : cp_oe_ff[g];
  end

endmodule : tbd_brake_deadtime
`default_nettype wire

// ### test/tbd_brake_deadtime_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tbd_brake_deadtime_asserts
  import tbd_pkg::*;
#(
  parameter int unsigned NCH = 4
) (
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [11:0]    paddr,
  input wire logic [31:0]    pwdata,
  input wire logic           pready,
  input wire logic [31:0]    prdata,
  input wire logic           pslverr,
  input wire logic           break_input,
  input wire logic [NCH-1:0] channel_oe,
  input wire logic [NCH-1:0] complementary_oe
);
  // =====
  // shadow of software-written fields
  logic [15:0] sh_ff;
  logic        set_ff;
  logic        pol_d_ff;
  logic [3:0]  run_ff;
  logic [15:0] wmask;
  logic        wr_bdt;
  logic        rd_bdt;
  logic        brk_on;
  assign wr_bdt = psel && penable && pwrite && paddr == TBD_BDT_ADDR;
  assign rd_bdt = psel && penable && !pwrite && paddr == TBD_BDT_ADDR;
  assign wmask  = (set_ff ? ~TBD_LOCK_FLD : 16'hFFFF)
                & (sh_ff[9:8] != 2'h0 ? ~TBD_L1_MASK : 16'hFFFF)
                & (sh_ff[9] ? ~TBD_L2_MASK : 16'hFFFF);
  assign brk_on = sh_ff[12] && break_input == sh_ff[13] && pol_d_ff == sh_ff[13];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_ff    <= TBD_BDT_RST;
      set_ff   <= 1'h0;
      pol_d_ff <= 1'h0;
      run_ff   <= 4'h0;
    end else begin
      if (wr_bdt) begin
        sh_ff  <= (sh_ff & ~wmask) | (pwdata[15:0] & wmask);
        set_ff <= 1'h1;
      end
      pol_d_ff <= sh_ff[13];
      run_ff   <= !brk_on ? 4'h0 : run_ff + {3'h0, run_ff != 4'hF};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====
  // properties
  property p_dtc;
    rd_bdt |-> prdata[7:0] == sh_ff[7:0];
  endproperty
  a_dtc: assert property (p_dtc) else $error("dead time code changed");
  property p_l1;
    rd_bdt |-> prdata[14:12] == sh_ff[14:12];
  endproperty
  a_l1: assert property (p_l1) else $error("break or auto field wrong");
  property p_l2;
    rd_bdt |-> prdata[11:10] == sh_ff[11:10];
  endproperty
  a_l2: assert property (p_l2) else $error("off select field wrong");
  property p_lock;
    rd_bdt && set_ff |-> prdata[9:8] == sh_ff[9:8];
  endproperty
  a_lock: assert property (p_lock) else $error("lock level rewritten");
  property p_brk_oe;
    run_ff >= 4'h2 && !sh_ff[10] |-> channel_oe == '0 && complementary_oe == '0;
  endproperty
  a_brk_oe: assert property (p_brk_oe) else $error("outputs driven in break");
  property p_brk_moe;
    rd_bdt && run_ff >= 4'h7 |-> !prdata[15];
  endproperty
  a_brk_moe: assert property (p_brk_moe) else $error("main enable kept in break");
  property p_err;
    pslverr |-> psel && penable && paddr != TBD_BDT_ADDR;
  endproperty
  a_err: assert property (p_err) else $error("error on mapped access");
  property p_rdy;
    psel && penable |-> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
endmodule : tbd_brake_deadtime_asserts
bind tbd_brake_deadtime tbd_brake_deadtime_asserts #(.NCH(NCH)) tbd_brake_deadtime_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .break_input(break_input), .channel_oe(channel_oe), .complementary_oe(complementary_oe));
`default_nettype wire

// ### test/tbd_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module tbd_stage_model #(
  parameter int unsigned NCH = 4
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           brk_req,
  input  wire logic [NCH-1:0] hi_out,
  input  wire logic [NCH-1:0] hi_oe,
  input  wire logic [NCH-1:0] lo_out,
  input  wire logic [NCH-1:0] lo_oe,
  output logic                break_input,
  output logic                shoot_ff
);
  // =====
  // break source, push-pull at all times
  assign break_input = brk_req;
  // =====
  // power stage: both switches of one leg on together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      shoot_ff <= 1'h0;
    else if (|(hi_oe & hi_out & lo_oe & lo_out))
      shoot_ff <= 1'h1;
  end
endmodule : tbd_stage_model
`default_nettype wire

// ### test/tbd_brake_deadtime_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tbd_brake_deadtime_tb
  import tbd_pkg::*;
;
  // =====
  // signals
  logic        pclk, presetn, psel, penable, pwrite, update_evt, brk_req;
  logic        pready, pslverr, irq, break_input, shoot_ff, err;
  logic [11:0] paddr, cmode;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  ref_wave, ch_out, ch_oe, cp_out, cp_oe, cpre;
  int          num_errors, num_checks, seed, m_bdt, m_set, base, d, c, m;
  logic [7:0]  codes [5] = '{8'h00, 8'h05, 8'h80, 8'hC0, 8'hE0};
  logic [11:0] regs [5] = '{TBD_BDT_ADDR, TBD_CHAN_ADDR, TBD_CMP_ADDR,
                            TBD_STAT_ADDR, TBD_MASK_ADDR};
  tbd_brake_deadtime #(.NCH(4)) tbd_brake_deadtime_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .break_input(break_input), .update_evt(update_evt), .ref_wave(ref_wave),
    .channel_output(ch_out), .channel_oe(ch_oe), .complementary_output(cp_out),
    .complementary_oe(cp_oe), .compare_mode(cmode), .compare_preload_enable(cpre), .irq(irq));
  tbd_stage_model #(.NCH(4)) tbd_stage_model_i (
    .pclk(pclk), .presetn(presetn), .brk_req(brk_req), .hi_out(ch_out), .hi_oe(ch_oe),
    .lo_out(cp_out), .lo_oe(cp_oe), .break_input(break_input), .shoot_ff(shoot_ff));
  always #5 pclk = ~pclk;
  // =====
  // tasks
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic stall();
    $display("unexpected at %0t: wait ran out", $time);
    num_errors++;
    test_done();
  endtask : stall
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n == 50) stall();
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wbdt(input int v);
    m = 16'hFFFF;
    if (m_set) m &= ~TBD_LOCK_FLD;
    if (m_bdt[9:8] != 0) m &= ~TBD_L1_MASK;
    if (m_bdt[9]) m &= ~TBD_L2_MASK;
    m_bdt = (m_bdt & ~m) | (v & m);
    m_set = 1;
    apb(1'h1, TBD_BDT_ADDR, v);
  endtask : wbdt
  task automatic do_reset();
    presetn <= 1'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    m_bdt = 0;
    m_set = 0;
  endtask : do_reset
  function automatic int ticks(input int k);
    if (k < 128) return k;
    if (k < 192) return (64 + k % 64) * 2;
    return (32 + k % 32) * (k < 224 ? 8 : 16);
  endfunction : ticks
  // =====
  // sequence
  initial begin
    {pclk, psel, penable, pwrite, update_evt, brk_req} = '0;
    {paddr, pwdata, ref_wave, num_errors, num_checks} = '0;
    seed = 32'h82F822C0;
    do_reset();
    foreach (regs[i]) begin
      apb(1'h0, regs[i], 0);
      chk(rd, 0);
    end
    apb(1'h0, 12'h0FC, 0);
    chk({rd[30:0], err}, 1);
    $display("test reset done");
    apb(1'h1, TBD_CHAN_ADDR, 32'h5);
    for (int i = 0; i < 5; i++) begin
      c = codes[i] | (i > 0 ? $random(seed) & 8'h1F : 0);
      ref_wave <= 4'h0;
      wbdt(32'h8000 | c);
      repeat (1100) @(posedge pclk);
      ref_wave <= 4'(($random(seed) << 1) | 1);
      d = 0;
      while (ch_out[0] !== 1'h1 && d < 1200) begin
        @(posedge pclk);
        d++;
      end
      if (d == 1200) stall();
      if (i == 0) base = d;
      chk(d - base, ticks(c));
    end
    chk(shoot_ff, 0);
    $display("test dead time done");
    apb(1'h1, TBD_CHAN_ADDR, 32'h11);
    wbdt(32'h8810);
    repeat (3) @(posedge pclk);
    chk({cp_oe[0], cp_out[0]}, 2'h2);
    wbdt(32'h0410);
    repeat (3) @(posedge pclk);
    chk({ch_oe[0], ch_out[0]}, 2'h2);
    repeat (20) @(posedge pclk);
    chk({ch_oe[0], ch_out[0]}, 2'h3);
    wbdt(32'h0010);
    repeat (3) @(posedge pclk);
    chk({ch_oe[0], cp_oe[0]}, 0);
    $display("test off state done");
    for (int l = 0; l < 4; l++) begin
      do_reset();
      wbdt(l << 8);
      wbdt(32'h7BFF);
      apb(1'h1, TBD_CHAN_ADDR, '1);
      apb(1'h1, TBD_CMP_ADDR, '1);
      apb(1'h0, TBD_BDT_ADDR, 0);
      chk(rd, m_bdt);
      m = (l > 0 ? TBD_CH_IDLE_M : 0) | (l > 1 ? TBD_CH_POL_M : 0);
      apb(1'h0, TBD_CHAN_ADDR, 0);
      chk(rd, ~{4{6'(m)}} & 32'hFFFFFF);
      apb(1'h0, TBD_CMP_ADDR, 0);
      chk(rd, l == 3 ? 0 : 32'hFFFF);
      chk({cpre, cmode}, l == 3 ? 0 : 16'hFFFF);
    end
    $display("test lock done");
    do_reset();
    brk_req <= 1'h1;
    apb(1'h1, TBD_CHAN_ADDR, 32'h5);
    apb(1'h1, TBD_MASK_ADDR, 32'h3);
    wbdt(32'hD000);
    apb(1'h0, TBD_BDT_ADDR, 0);
    chk(rd, m_bdt);
    chk(ch_oe[0], 1);
    chk(irq, 0);
    @(posedge pclk);
    brk_req <= 1'h0;
    #1;
    chk(ch_oe, 0);
    repeat (5) @(posedge pclk);
    m_bdt &= ~32'h8000;
    apb(1'h0, TBD_BDT_ADDR, 0);
    chk(rd, m_bdt);
    chk(irq, 1);
    apb(1'h0, TBD_STAT_ADDR, 0);
    chk(rd, 1);
    apb(1'h0, TBD_STAT_ADDR, 0);
    chk(rd, 0);
    chk(irq, 0);
    brk_req <= 1'h1;
    repeat (4) @(posedge pclk);
    update_evt <= 1'h1;
    @(posedge pclk);
    update_evt <= 1'h0;
    apb(1'h1, TBD_MASK_ADDR, 0);
    m_bdt |= 32'h8000;
    apb(1'h0, TBD_BDT_ADDR, 0);
    chk(rd, m_bdt);
    chk(irq, 0);
    apb(1'h0, TBD_STAT_ADDR, 0);
    chk(rd, 2);
    wbdt(32'hF000);
    repeat (6) @(posedge pclk);
    apb(1'h0, TBD_BDT_ADDR, 0);
    chk(rd, m_bdt & ~32'h8000);
    $display("test break done");
    test_done();
  end
endmodule : tbd_brake_deadtime_tb
`default_nettype wire
